// File: event_mask_defs.vh
/*
  Constants for the protection event masking block: mask reset values,
  event code bases, access kinds, data item indexes and value limits.
  Assumes inclusion by bare name from the design files.
*/
`ifndef EVENT_MASK_DEFS_VH
`define EVENT_MASK_DEFS_VH

`define EU_MASK_RESET 8'h44
`define UC_MASK_RESET 8'h14
`define OUT_MASK_RESET 10'h300
`define EIGHT_MASK_MAX 16'h00FF
`define OUT_MASK_MAX 16'h03FF

`define EU_CODE_BASE 6'h11
`define UC_CODE_BASE 6'h19
`define OUT_CODE_BASE 6'h21
`define RESTART_CODE 6'h32
`define OVERFLOW_CODE 6'h33

`define START_EVENT_SET 26'h0000333

`define DATA_CHANNEL 4'h0
`define KIND_INPUT 2'h0
`define KIND_VALUE 2'h1
`define KIND_EVENT 2'h2

`define IDX_PHASE1 8'h01
`define IDX_PHASE2 8'h02
`define IDX_PHASE3 8'h03
`define IDX_NEUTRAL 8'h04
`define IDX_BLOCKING 8'h05
`define IDX_EU_MASK 8'h9D
`define IDX_UC_MASK 8'h9E
`define IDX_OUT_MASK 8'h9F

`define EVENT_VALID_BIT 15

`endif

// File: level_edges.v
/*
  Rising and falling edge pulses for a vector of synchronous levels.
  Assumes levels synchronous to core_clk; no edges in the first cycle after reset.
*/
`timescale 1ns/1ps
module level_edges #(
  parameter WIDTH = 13
) (
  input wire core_clk,
  input wire rstn,
  input wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] fall
);
  reg [WIDTH-1:0] prev_reg;
  reg primed_reg;

  always @(posedge core_clk) begin
    if (!rstn) begin
      prev_reg <= {WIDTH{1'b0}};
      primed_reg <= 1'b0;
    end else begin
      prev_reg <= level;
      primed_reg <= 1'b1;
    end
  end

  assign rise = primed_reg ? (level & ~prev_reg) : {WIDTH{1'b0}};
  assign fall = primed_reg ? (~level & prev_reg) : {WIDTH{1'b0}};
endmodule // level_edges

// File: pem_asserts.sv
/* Access port checker. Assumes a bind to the masking block's top module. */
`timescale 1ns/1ps
module pem_asserts (
  input wire core_clk,
  input wire rstn,
  input wire acc_req,
  input wire acc_wr,
  input wire [3:0] acc_chan,
  input wire [1:0] acc_kind,
  input wire [7:0] acc_index,
  input wire [15:0] acc_wdata,
  input wire acc_ack,
  input wire acc_err,
  input wire [15:0] acc_rdata,
  input wire [7:0] earth_unbalance_event_mask,
  input wire [7:0] undercurrent_external_event_mask,
  input wire [9:0] output_signal_event_mask
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire mw = acc_req && acc_wr && acc_chan == 4'h0 && acc_kind == 2'h1;
  wire [9:0] wd10 = acc_wdata[9:0];
  ack_after_req_a: assert property (acc_req |=> acc_ack) else $error("missing ack");
  ack_cause_a: assert property (acc_ack |-> $past(acc_req)) else $error("stray ack");
  chan_refused_a: assert property (acc_req && acc_chan != 4'h0 |=> acc_err)
    else $error("other channel served");
  input_ro_a: assert property (acc_req && acc_wr && acc_kind == 2'h0 |=> acc_err)
    else $error("input written");
  eu_range_a: assert property (mw && acc_index == 8'h9D && acc_wdata > 16'h00FF
    |=> acc_err && $stable(earth_unbalance_event_mask)) else $error("mask range");
  out_range_a: assert property (mw && acc_index == 8'h9F && acc_wdata > 16'h03FF
    |=> acc_err && $stable(output_signal_event_mask)) else $error("mask range");
  out_write_a: assert property (mw && acc_index == 8'h9F && acc_wdata <= 16'h03FF
    |=> !acc_err && output_signal_event_mask == $past(wd10)) else $error("mask write");
  idle_data_a: assert property (!acc_ack |-> acc_rdata == 16'h0000)
    else $error("stray data");
  event_read_a: assert property (acc_req && !acc_wr && acc_chan == 4'h0 && acc_kind == 2'h2
    |=> !acc_err && (acc_rdata == 16'h0000 || acc_rdata[15:6] == 10'h200 &&
    (acc_rdata[5:0] >= 6'h11 && acc_rdata[5:0] <= 6'h2A || acc_rdata[5:0] == 6'h32 ||
    acc_rdata[5:0] == 6'h33))) else $error("bad event word");
  reset_masks_a: assert property (disable iff (1'b0) !rstn |=>
    earth_unbalance_event_mask == 8'h44 && undercurrent_external_event_mask == 8'h14
    && output_signal_event_mask == 10'h300) else $error("mask reset");
endmodule // pem_asserts

// File: protection_event_masking.v
/*
  Event detection, masking, queuing and remote data access of a motor
  protection module. Assumes the remote communicator issues one-cycle
  requests synchronous to core_clk and that all status inputs are synchronous.
*/
`timescale 1ns/1ps
`include "event_mask_defs.vh"
module protection_event_masking #(
  parameter QUEUE_DEPTH = 8,
  parameter QUEUE_AW = 3,
  parameter CURRENT_W = 16
) (
  input wire core_clk,
  input wire rstn,
  input wire earth_start,
  input wire earth_trip,
  input wire unbalance_start,
  input wire unbalance_trip,
  input wire undercurrent_start,
  input wire undercurrent_trip,
  input wire external_trip,
  input wire restart_inhibit,
  input wire restart_enable_output,
  input wire motor_start_output,
  input wire second_signal_output,
  input wire first_signal_output,
  input wire trip_output,
  input wire motor_startup,
  input wire [CURRENT_W-1:0] phase1_current,
  input wire [CURRENT_W-1:0] phase2_current,
  input wire [CURRENT_W-1:0] phase3_current,
  input wire [CURRENT_W-1:0] neutral_current,
  input wire blocking_input_item,
  input wire acc_req,
  input wire acc_wr,
  input wire [3:0] acc_chan,
  input wire [1:0] acc_kind,
  input wire [7:0] acc_index,
  input wire [15:0] acc_wdata,
  output reg acc_ack,
  output reg acc_err,
  output reg [15:0] acc_rdata,
  output wire [7:0] earth_unbalance_event_mask,
  output wire [7:0] undercurrent_external_event_mask,
  output wire [9:0] output_signal_event_mask
);

  ////////////////////////////////////////////////////////////////////////////
  // Level edges and event sources.

  localparam NLEV = 13;
  localparam NEV = 26;
  localparam NPEND = 28;
  localparam P_RESTART = 26;
  localparam P_OVERFLOW = 27;

  wire [NLEV-1:0] levels;
  wire [NLEV-1:0] rise;
  wire [NLEV-1:0] fall;
  wire [NEV-1:0] src;

  // Each level gives activation at even weight and reset at the next.
  assign levels = {trip_output, first_signal_output, second_signal_output,
                   motor_start_output, restart_enable_output,
                   restart_inhibit, external_trip,
                   undercurrent_trip, undercurrent_start,
                   unbalance_trip, unbalance_start, earth_trip, earth_start};

  level_edges #(.WIDTH(NLEV)) edges_u (
    .core_clk(core_clk),
    .rstn(rstn),
    .level(levels),
    .rise(rise),
    .fall(fall)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NLEV; gi = gi + 1) begin : pair_gen
      assign src[2*gi] = rise[gi];
      assign src[2*gi+1] = fall[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Event masks.

  reg [7:0] eu_mask_reg;
  reg [7:0] uc_mask_reg;
  reg [9:0] out_mask_reg;
  wire [NEV-1:0] full_mask;
  wire [NEV-1:0] start_block;
  wire [NEV-1:0] qualified;

  assign earth_unbalance_event_mask = eu_mask_reg;
  assign undercurrent_external_event_mask = uc_mask_reg;
  assign output_signal_event_mask = out_mask_reg;

  assign full_mask = {out_mask_reg, uc_mask_reg, eu_mask_reg};
  assign start_block = motor_startup ? `START_EVENT_SET : {NEV{1'b0}};
  // Current mask decides at detection time; queued events stay untouched.
  assign qualified = src & full_mask & ~start_block;

  ////////////////////////////////////////////////////////////////////////////
  // Pending events and priority selection.

  reg [NPEND-1:0] pend_reg;
  reg [NPEND-1:0] pend_next;
  reg [NPEND-1:0] grant;
  reg [5:0] grant_code;
  reg grant_any;
  reg [QUEUE_AW:0] q_count;
  wire [NPEND-1:0] arrive;
  wire lost;
  wire push;
  integer k;

  function [5:0] event_code;
    input integer idx;
    begin
      if (idx < 8) begin
        event_code = `EU_CODE_BASE + idx[5:0];
      end else if (idx < 16) begin
        event_code = `UC_CODE_BASE + idx[5:0] - 6'h08;
      end else begin
        event_code = `OUT_CODE_BASE + idx[5:0] - 6'h10;
      end
    end
  endfunction

  always @* begin
    grant = {NPEND{1'b0}};
    grant_code = 6'h00;
    grant_any = 1'b0;
    if (pend_reg[P_OVERFLOW]) begin
      grant[P_OVERFLOW] = 1'b1;
      grant_code = `OVERFLOW_CODE;
      grant_any = 1'b1;
    end else if (pend_reg[P_RESTART]) begin
      grant[P_RESTART] = 1'b1;
      grant_code = `RESTART_CODE;
      grant_any = 1'b1;
    end else begin
      for (k = NEV - 1; k >= 0; k = k - 1) begin
        if (pend_reg[k]) begin
          grant = {NPEND{1'b0}};
          grant[k] = 1'b1;
          grant_code = event_code(k);
          grant_any = 1'b1;
        end
      end
    end
  end

  // A second occurrence of a still-pending event is lost and flags overflow.
  assign lost = |(qualified & pend_reg[NEV-1:0] & ~(grant[NEV-1:0] & {NEV{push}}));
  assign arrive = {lost, 1'b0, qualified};
  assign push = grant_any & (q_count != QUEUE_DEPTH[QUEUE_AW:0]);

  always @* begin
    pend_next = pend_reg;
    if (push) begin
      pend_next = pend_reg & ~grant;
    end
    pend_next = pend_next | arrive;
  end

  always @(posedge core_clk) begin
    if (!rstn) begin
      pend_reg <= {1'b0, 1'b1, {NEV{1'b0}}};
    end else begin
      pend_reg <= pend_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event queue.

  reg [5:0] q_mem [0:QUEUE_DEPTH-1];
  reg [QUEUE_AW-1:0] q_wr_reg;
  reg [QUEUE_AW-1:0] q_rd_reg;
  wire is_req;
  wire pop;
  wire q_empty;

  assign q_empty = (q_count == {(QUEUE_AW+1){1'b0}});
  assign is_req = acc_req & (acc_chan == `DATA_CHANNEL);
  assign pop = is_req & ~acc_wr & (acc_kind == `KIND_EVENT) & ~q_empty;

  always @(posedge core_clk) begin
    if (push) begin
      q_mem[q_wr_reg] <= grant_code;
    end
  end

  always @(posedge core_clk) begin
    if (!rstn) begin
      q_wr_reg <= {QUEUE_AW{1'b0}};
      q_rd_reg <= {QUEUE_AW{1'b0}};
      q_count <= {(QUEUE_AW+1){1'b0}};
    end else begin
      if (push) begin
        q_wr_reg <= q_wr_reg + {{(QUEUE_AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        q_rd_reg <= q_rd_reg + {{(QUEUE_AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        q_count <= q_count + {{QUEUE_AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        q_count <= q_count - {{QUEUE_AW{1'b0}}, 1'b1};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Remote data access on channel zero.

  reg [15:0] rdata_next;
  reg err_next;
  wire wr_eu;
  wire wr_uc;
  wire wr_out;

  assign wr_eu = is_req & acc_wr & (acc_kind == `KIND_VALUE) &
                 (acc_index == `IDX_EU_MASK) & (acc_wdata <= `EIGHT_MASK_MAX);
  assign wr_uc = is_req & acc_wr & (acc_kind == `KIND_VALUE) &
                 (acc_index == `IDX_UC_MASK) & (acc_wdata <= `EIGHT_MASK_MAX);
  assign wr_out = is_req & acc_wr & (acc_kind == `KIND_VALUE) &
                  (acc_index == `IDX_OUT_MASK) & (acc_wdata <= `OUT_MASK_MAX);

  always @(posedge core_clk) begin
    if (!rstn) begin
      eu_mask_reg <= `EU_MASK_RESET;
      uc_mask_reg <= `UC_MASK_RESET;
      out_mask_reg <= `OUT_MASK_RESET;
    end else begin
      if (wr_eu) begin
        eu_mask_reg <= acc_wdata[7:0];
      end
      if (wr_uc) begin
        uc_mask_reg <= acc_wdata[7:0];
      end
      if (wr_out) begin
        out_mask_reg <= acc_wdata[9:0];
      end
    end
  end

  always @* begin
    rdata_next = 16'h0000;
    err_next = 1'b0;
    if (!is_req) begin
      err_next = 1'b1;
    end else if (acc_wr) begin
      err_next = ~(wr_eu | wr_uc | wr_out);
    end else begin
      case (acc_kind)
        `KIND_INPUT: begin
          case (acc_index)
            `IDX_PHASE1: rdata_next = phase1_current;
            `IDX_PHASE2: rdata_next = phase2_current;
            `IDX_PHASE3: rdata_next = phase3_current;
            `IDX_NEUTRAL: rdata_next = neutral_current;
            `IDX_BLOCKING: rdata_next = {15'h0000, blocking_input_item};
            default: err_next = 1'b1;
          endcase
        end
        `KIND_VALUE: begin
          case (acc_index)
            `IDX_EU_MASK: rdata_next = {8'h00, eu_mask_reg};
            `IDX_UC_MASK: rdata_next = {8'h00, uc_mask_reg};
            `IDX_OUT_MASK: rdata_next = {6'h00, out_mask_reg};
            default: err_next = 1'b1;
          endcase
        end
        `KIND_EVENT: begin
          if (!q_empty) begin
            rdata_next = {1'b1, 9'h000, q_mem[q_rd_reg]};
          end
        end
        default: err_next = 1'b1;
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (!rstn) begin
      acc_ack <= 1'b0;
      acc_err <= 1'b0;
      acc_rdata <= 16'h0000;
    end else begin
      acc_ack <= acc_req;
      acc_err <= acc_req & err_next;
      acc_rdata <= acc_req ? rdata_next : 16'h0000;
    end
  end

  // Communication-loss events are produced by the remote unit, not here.

endmodule // protection_event_masking

// File: protection_event_masking_bench.sv
/* Bench: access table, event sweeps, start-up, second reset, overflow.
   Assumes the model and checker files are compiled before it. */
`timescale 1ns/1ps
module protection_event_masking_bench;
  typedef struct packed {logic wr; logic [3:0] ch; logic [1:0] kd; logic [7:0] ix;
    logic er; logic [15:0] d;} row_t;
  row_t rows [23] = '{
    '{1'b0, 4'h0, 2'h2, 8'h00, 1'b0, 16'h8032},
    '{1'b0, 4'h0, 2'h1, 8'h9D, 1'b0, 16'h0044},
    '{1'b0, 4'h0, 2'h1, 8'h9E, 1'b0, 16'h0014},
    '{1'b0, 4'h0, 2'h1, 8'h9F, 1'b0, 16'h0300},
    '{1'b0, 4'h0, 2'h0, 8'h01, 1'b0, 16'h1A01},
    '{1'b0, 4'h0, 2'h0, 8'h02, 1'b0, 16'h1A02},
    '{1'b0, 4'h0, 2'h0, 8'h03, 1'b0, 16'h1A03},
    '{1'b0, 4'h0, 2'h0, 8'h04, 1'b0, 16'h1A04},
    '{1'b0, 4'h0, 2'h0, 8'h05, 1'b0, 16'h0001},
    '{1'b0, 4'h0, 2'h0, 8'h06, 1'b1, 16'h0000},
    '{1'b0, 4'h0, 2'h3, 8'h01, 1'b1, 16'h0000},
    '{1'b1, 4'h0, 2'h2, 8'h00, 1'b1, 16'h0000},
    '{1'b1, 4'h0, 2'h0, 8'h01, 1'b1, 16'h0000},
    '{1'b0, 4'h1, 2'h1, 8'h9D, 1'b1, 16'h0000},
    '{1'b1, 4'h0, 2'h1, 8'h9D, 1'b1, 16'h0100},
    '{1'b1, 4'h0, 2'h1, 8'h9E, 1'b1, 16'h0100},
    '{1'b1, 4'h0, 2'h1, 8'h9F, 1'b1, 16'h0400},
    '{1'b1, 4'h0, 2'h1, 8'h9D, 1'b0, 16'h00FF},
    '{1'b1, 4'h0, 2'h1, 8'h9E, 1'b0, 16'h00FF},
    '{1'b1, 4'h0, 2'h1, 8'h9F, 1'b0, 16'h03FF},
    '{1'b0, 4'h0, 2'h1, 8'h9D, 1'b0, 16'h00FF},
    '{1'b0, 4'h0, 2'h1, 8'h9E, 1'b0, 16'h00FF},
    '{1'b0, 4'h0, 2'h1, 8'h9F, 1'b0, 16'h03FF}
  };
  reg core_clk = 1'b0;
  reg rstn = 1'b0;
  reg startup = 1'b0;
  reg blk = 1'b1;
  reg [12:0] lv = 13'h0000;
  wire acc_req, acc_wr, acc_err;
  wire [3:0] acc_chan;
  wire [1:0] acc_kind;
  wire [7:0] acc_index;
  wire [15:0] acc_wdata, acc_rdata;
  logic er;
  logic hit;
  logic [15:0] rd;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  int k;
  always #50 core_clk = ~core_clk;
  protection_event_masking protection_event_masking_i (
    .core_clk(core_clk), .rstn(rstn), .earth_start(lv[0]), .earth_trip(lv[1]),
    .unbalance_start(lv[2]), .unbalance_trip(lv[3]), .undercurrent_start(lv[4]),
    .undercurrent_trip(lv[5]), .external_trip(lv[6]), .restart_inhibit(lv[7]),
    .restart_enable_output(lv[8]), .motor_start_output(lv[9]),
    .second_signal_output(lv[10]), .first_signal_output(lv[11]), .trip_output(lv[12]),
    .motor_startup(startup), .phase1_current(16'h1A01), .phase2_current(16'h1A02),
    .phase3_current(16'h1A03), .neutral_current(16'h1A04), .blocking_input_item(blk),
    .acc_req(acc_req), .acc_wr(acc_wr), .acc_chan(acc_chan), .acc_kind(acc_kind),
    .acc_index(acc_index), .acc_wdata(acc_wdata), .acc_ack(), .acc_err(acc_err),
    .acc_rdata(acc_rdata), .earth_unbalance_event_mask(),
    .undercurrent_external_event_mask(), .output_signal_event_mask());
  remote_communicator remote_communicator_i (.core_clk(core_clk), .acc_err(acc_err),
    .acc_rdata(acc_rdata), .acc_req(acc_req), .acc_wr(acc_wr), .acc_chan(acc_chan),
    .acc_kind(acc_kind), .acc_index(acc_index), .acc_wdata(acc_wdata));
  task end_sim;
    begin
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      compares++;
      if (got !== exp) begin
        error_cnt++;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task acc(input row_t r);
    begin
      remote_communicator_i.access(r.wr, r.ch, r.kd, r.ix, r.d, er, rd);
      chk({15'h0000, er}, {15'h0000, r.er});
      if (!r.wr && !r.er)
        chk(rd, r.d);
    end
  endtask
  task sweep(input logic [25:0] m);
    int i;
    int e;
    logic [5:0] c;
    begin
      for (i = 0; i < 13; i++) begin
        for (e = 0; e < 2; e++) begin
          lv[i] = (e == 0);
          repeat (3) @(posedge core_clk);
          c = 6'(17 + 2 * i + e);
          acc('{1'b0, 4'h0, 2'h2, 8'h00, 1'b0, (m[2 * i + e] && !(startup && i < 5 &&
            i % 2 == 0)) ? {10'h200, c} : 16'h0000});
        end
      end
    end
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      end_sim;
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge core_clk);
    #10;
    rstn = 1'b1;
    foreach (rows[j])
      acc(rows[j]);
    sweep(26'h3FFFFFF);
    startup = 1'b1;
    sweep(26'h3FFFFFF);
    startup = 1'b0;
    rstn = 1'b0;
    repeat (2) @(posedge core_clk);
    #10;
    rstn = 1'b1;
    acc('{1'b0, 4'h0, 2'h2, 8'h00, 1'b0, 16'h8032});
    blk = 1'b0;
    acc('{1'b0, 4'h0, 2'h0, 8'h05, 1'b0, 16'h0000});
    sweep(26'h3001444);
    for (k = 0; k < 24; k++) begin
      lv[12] = ~lv[12];
      repeat (2) @(posedge core_clk);
      #10;
    end
    hit = 1'b0;
    for (k = 0; k < 16; k++) begin
      remote_communicator_i.access(1'b0, 4'h0, 2'h2, 8'h00, 16'h0000, er, rd);
      hit = hit | (rd === 16'h8033);
    end
    chk({15'h0000, hit}, 16'h0001);
    end_sim;
  end
endmodule // protection_event_masking_bench
bind protection_event_masking pem_asserts pem_asserts_i (.core_clk(core_clk), .rstn(rstn),
  .acc_req(acc_req), .acc_wr(acc_wr), .acc_chan(acc_chan), .acc_kind(acc_kind),
  .acc_index(acc_index), .acc_wdata(acc_wdata), .acc_ack(acc_ack), .acc_err(acc_err),
  .acc_rdata(acc_rdata), .earth_unbalance_event_mask(earth_unbalance_event_mask),
  .undercurrent_external_event_mask(undercurrent_external_event_mask),
  .output_signal_event_mask(output_signal_event_mask));

// File: remote_communicator.sv
/* Remote communicator model. Assumes an answer registered on the taking edge and read 10 ns after it. */
`timescale 1ns/1ps
module remote_communicator (
  input wire core_clk,
  input wire acc_err,
  input wire [15:0] acc_rdata,
  output reg acc_req,
  output reg acc_wr,
  output reg [3:0] acc_chan,
  output reg [1:0] acc_kind,
  output reg [7:0] acc_index,
  output reg [15:0] acc_wdata
);
  initial {acc_req, acc_wr, acc_chan, acc_kind, acc_index, acc_wdata} = 32'h00000000;
  // Link-loss and link-recovery events belong to this unit, never to the block.
  task access(input logic w, input logic [3:0] c, input logic [1:0] k,
    input logic [7:0] i, input logic [15:0] d, output logic e, output logic [15:0] r);
    begin
      @(posedge core_clk);
      #10;
      {acc_req, acc_wr, acc_chan, acc_kind, acc_index, acc_wdata} = {1'b1, w, c, k, i, d};
      @(posedge core_clk);
      #10;
      e = acc_err;
      r = acc_rdata;
      acc_req = 1'b0;
      acc_index = ~i;
      acc_wdata = ~d;
    end
  endtask
endmodule // remote_communicator
